// [hdl/xfer_ctl_params.svh]
/*
 Constants of the transfer control.
 Assumes a 10 MHz clock and 16-bit CPU words.
*/
// Behaviour
// - Output and transition tables copied each sweep on jumper or request.
// - Return word copied backup to master each sweep on jumper or request.
// - Register bank copied master to backup each sweep on jumper or request.
// - Bank first register is the start pointer contents.
// - Bank last register is the end pointer contents.
// - Bank copy only with both pointers in 1 to 4096.
// - No bank copy when start exceeds end.
// - Init jumper set: all registers, tables and scratchpad to new backup.
// - Init starts when a CPU first becomes backup.
// - Init off: only the selected copies run.
// - Init only after a finished switch, backup on-line.
// - Flag jumper set moves the backup flag to the alternate point.
// - Sweep limit 150 ms at 2-3, 250 ms at 1-2.
// - Limit measures CPU scan time only.
// - Backup flag at point 1024 by default, 1022 alternate.
`ifndef XFER_CTL_PARAMS_SVH
`define XFER_CTL_PARAMS_SVH

`define RETURN_WORD_REG 13'h00FE
`define BANK_START_REG 13'h00FF
`define BANK_END_REG 13'h0100
`define REG_FIRST 13'h0001
`define REG_LAST 13'h1000
`define PTR_MIN 16'h0001
`define PTR_MAX 16'h1000
`define TABLE_FIRST 13'h0001
`define TABLE_LAST 13'h0040
`define SCRATCH_LAST 13'h0010
`define FLAG_POINT_DEFAULT 13'h0400
`define FLAG_POINT_ALT 13'h03FE
`define FLAG_ON 16'h0001

`define CLK_HZ 10000000
`define SWEEP_MAX_SHORT_MS 150
`define SWEEP_MAX_LONG_MS 250

`define OFS_STATUS 4'h0
`define OFS_CONTROL 4'h4
`define OFS_SWEEP_TIME 4'h8
`define OFS_SWEEP_COUNT 4'hC

`define CTL_CLEAR_FAULT 0
`define CTL_HOLD 1
`define ST_BUSY 0
`define ST_INIT_PENDING 1
`define ST_SWEEP_FAULT 2
`define ST_BANK_SKIPPED 3
`define ST_FLAG_ALT 4
`define ST_INIT_DONE 5

`define JOB_REGS 0
`define JOB_INPUT 1
`define JOB_OUTPUT 2
`define JOB_OVERRIDE 3
`define JOB_TRANS 4
`define JOB_SCRATCH 5
`define JOB_BANK 6
`define JOB_RETURN 7
`define JOB_FLAG 8
`define JOB_COUNT 9

`endif

// [hdl/xfer_ctl_pkg.sv]
/*
 Types of the transfer control.
 Assumes users include the constants header.
*/
package xfer_ctl_pkg;

    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001,
        S_PTR  = 7'b000_0010,
        S_EVAL = 7'b000_0100,
        S_PICK = 7'b000_1000,
        S_RUN  = 7'b001_0000,
        S_FLAG = 7'b010_0000,
        S_DONE = 7'b100_0000
    } state_t;

    typedef enum logic [2:0] {
        SP_REG      = 3'h0,
        SP_INPUT    = 3'h1,
        SP_OUTPUT   = 3'h2,
        SP_OVERRIDE = 3'h3,
        SP_TRANS    = 3'h4,
        SP_SCRATCH  = 3'h5,
        SP_BIT      = 3'h6
    } space_t;

endpackage : xfer_ctl_pkg

// [hdl/copy_walker.sv]
/*
 Word copy engine, first..last, source to destination.
 Assumes read data two cycles after rd_o.
*/
module copy_walker
    import xfer_ctl_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [12:0] first_i,
    input wire logic [12:0] last_i,
    input wire logic [15:0] rdata_i,
    output logic rd_o,
    output logic [12:0] rd_addr_o,
    output logic wr_o,
    output logic [12:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    output logic done_o
);

    logic busy_r, issuing_r, d1_r, d2_r;
    logic [12:0] addr_r, last_r, a1_r, a2_r;

    // Address issue
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            issuing_r <= 1'b0;
            addr_r <= 13'h0000;
            last_r <= 13'h0000;
            rd_o <= 1'b0;
            rd_addr_o <= 13'h0000;
        end
        else
        begin
            rd_o <= issuing_r;
            rd_addr_o <= addr_r;
            if (start_i)
            begin
                issuing_r <= 1'b1;
                addr_r <= first_i;
                last_r <= last_i;
            end
            else if (issuing_r)
            begin
                if (addr_r == last_r)
                    issuing_r <= 1'b0;
                else
                    addr_r <= addr_r + 13'h0001;
            end
        end
    end

    // Read latency pipe and write out
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            d1_r <= 1'b0;
            d2_r <= 1'b0;
            a1_r <= 13'h0000;
            a2_r <= 13'h0000;
            wr_o <= 1'b0;
            wr_addr_o <= 13'h0000;
            wr_data_o <= 16'h0000;
        end
        else
        begin
            d1_r <= rd_o;
            a1_r <= rd_addr_o;
            d2_r <= d1_r;
            a2_r <= a1_r;
            wr_o <= d2_r;
            wr_addr_o <= a2_r;
            wr_data_o <= rdata_i;
        end
    end

    // Completion once the pipe has drained
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
                busy_r <= 1'b1;
            else if (busy_r && !issuing_r && !rd_o && !d1_r && !d2_r)
            begin
                busy_r <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end

endmodule : copy_walker

// [hdl/redundant_cpu_data_transfer_control.sv]
/*
 Transfer selection, backup init and sweep supervision.
 Assumes CPU ports answer reads one cycle later; jumper 1 is 2-3.
*/
// Added by the designer: strobed register access and the placing of the registers.
`include "xfer_ctl_params.svh"

module redundant_cpu_data_transfer_control
    import xfer_ctl_pkg::*;
#(
    parameter int SWEEP_SHORT_CYC = (`CLK_HZ / 1000) * `SWEEP_MAX_SHORT_MS,
    parameter int SWEEP_LONG_CYC = (`CLK_HZ / 1000) * `SWEEP_MAX_LONG_MS
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic table_copy_select_i,
    input wire logic backup_to_master_select_i,
    input wire logic bank_copy_select_i,
    input wire logic backup_init_jumper_i,
    input wire logic backup_flag_location_jumper_i,
    input wire logic sweep_limit_jumper_i,
    input wire logic table_copy_request_output_i,
    input wire logic backup_to_master_request_output_i,
    input wire logic bank_copy_request_output_i,
    input wire logic backup_cpu_sel_i,
    input wire logic backup_online_i,
    input wire logic sweep_start_i,
    output logic mst_rd_o,
    output logic mst_wr_o,
    output logic [2:0] mst_space_o,
    output logic [12:0] mst_addr_o,
    output logic [15:0] mst_wdata_o,
    input wire logic [15:0] mst_rdata_i,
    output logic bak_rd_o,
    output logic bak_wr_o,
    output logic [2:0] bak_space_o,
    output logic [12:0] bak_addr_o,
    output logic [15:0] bak_wdata_o,
    input wire logic [15:0] bak_rdata_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic busy_o,
    output logic sweep_done_o,
    output logic sweep_fault_o
);

    state_t state_r, state_nxt;
    space_t space_r;
    logic [1:0] ptr_step_r;
    logic [15:0] start_ptr_r, end_ptr_r, sweep_count_r, w_wr_data, mst_wdata_nxt, bak_wdata_nxt;
    logic [`JOB_COUNT-1:0] en_r;
    logic [3:0] job_r, pick;
    logic [12:0] w_first_r, w_last_r, w_rd_addr, w_wr_addr, flag_point;
    logic [12:0] mst_addr_nxt, bak_addr_nxt;
    logic [21:0] sweep_cnt_r, sweep_last_r, sweep_limit;
    logic [2:0] mst_space_nxt, bak_space_nxt;
    logic [31:0] rdata_nxt;
    logic dir_r, w_start_r, w_rd, w_wr, w_done, prev_online_r, prev_sel_r, new_backup;
    logic init_pending_r, init_now, init_done_r, bank_ok, bank_skipped_r, hold_r, fault_r;
    logic mst_rd_nxt, mst_wr_nxt, bak_rd_nxt, bak_wr_nxt;

    // New backup: back on-line, or roles swapped
    assign new_backup = backup_online_i &&
        (!prev_online_r || (backup_cpu_sel_i != prev_sel_r));
    assign init_now = init_pending_r && backup_init_jumper_i;
    assign bank_ok = (start_ptr_r >= `PTR_MIN) && (start_ptr_r <= `PTR_MAX) &&
        (end_ptr_r >= `PTR_MIN) && (end_ptr_r <= `PTR_MAX);
    assign flag_point = backup_flag_location_jumper_i ?
        `FLAG_POINT_ALT : `FLAG_POINT_DEFAULT;
    assign sweep_limit = sweep_limit_jumper_i ?
        SWEEP_SHORT_CYC[21:0] : SWEEP_LONG_CYC[21:0];

    // Lowest pending job
    always_comb
    begin
        pick = 4'hF;
        for (int i = `JOB_COUNT - 1; i >= 0; i--)
            if (en_r[i])
                pick = 4'(i);
    end

    copy_walker u_walker (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(w_start_r),
        .first_i(w_first_r),
        .last_i(w_last_r),
        .rdata_i(dir_r ? bak_rdata_i : mst_rdata_i),
        .rd_o(w_rd),
        .rd_addr_o(w_rd_addr),
        .wr_o(w_wr),
        .wr_addr_o(w_wr_addr),
        .wr_data_o(w_wr_data),
        .done_o(w_done)
    );

    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE:
                if (sweep_start_i && !hold_r)
                    state_nxt = S_PTR;
            S_PTR:
                if (ptr_step_r == 2'h3)
                    state_nxt = S_EVAL;
            S_EVAL:
                state_nxt = S_PICK;
            S_PICK:
                if (pick == 4'hF)
                    state_nxt = S_DONE;
                else if (pick == 4'(`JOB_FLAG))
                    state_nxt = S_FLAG;
                else
                    state_nxt = S_RUN;
            S_RUN:
                if (w_done)
                    state_nxt = S_PICK;
            S_FLAG:
                state_nxt = S_PICK;
            S_DONE:
                state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= S_IDLE;
            busy_o <= 1'b0;
            sweep_done_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            busy_o <= (state_nxt != S_IDLE);
            sweep_done_o <= (state_r == S_DONE);
        end
    end

    // Pointer fetch from the master
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ptr_step_r <= 2'h0;
            start_ptr_r <= 16'h0000;
            end_ptr_r <= 16'h0000;
        end
        else if (state_r == S_PTR)
        begin
            ptr_step_r <= ptr_step_r + 2'h1;
            if (ptr_step_r == 2'h2)
                start_ptr_r <= mst_rdata_i;
            if (ptr_step_r == 2'h3)
                end_ptr_r <= mst_rdata_i;
        end
        else
            ptr_step_r <= 2'h0;
    end

    // Job enables per sweep
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            en_r <= '0;
            bank_skipped_r <= 1'b0;
            init_done_r <= 1'b0;
        end
        else if (state_r == S_EVAL)
        begin
            en_r <= '0;
            en_r[`JOB_REGS] <= init_now;
            en_r[`JOB_INPUT] <= init_now;
            en_r[`JOB_OVERRIDE] <= init_now;
            en_r[`JOB_SCRATCH] <= init_now;
            en_r[`JOB_OUTPUT] <= init_now || table_copy_select_i ||
                table_copy_request_output_i;
            en_r[`JOB_TRANS] <= init_now || table_copy_select_i ||
                table_copy_request_output_i;
            en_r[`JOB_BANK] <= (bank_copy_select_i || bank_copy_request_output_i) &&
                bank_ok && (start_ptr_r <= end_ptr_r);
            en_r[`JOB_RETURN] <= backup_to_master_select_i ||
                backup_to_master_request_output_i;
            en_r[`JOB_FLAG] <= 1'b1;
            bank_skipped_r <= (bank_copy_select_i || bank_copy_request_output_i) &&
                !(bank_ok && (start_ptr_r <= end_ptr_r));
            init_done_r <= init_now;
        end
        else if (state_r == S_PICK && pick != 4'hF)
            en_r[pick] <= 1'b0;
    end

    // Job parameters and walker launch
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            job_r <= 4'h0;
            dir_r <= 1'b0;
            space_r <= SP_REG;
            w_start_r <= 1'b0;
            w_first_r <= 13'h0000;
            w_last_r <= 13'h0000;
        end
        else
        begin
            w_start_r <= 1'b0;
            if (state_r == S_PICK && pick != 4'hF)
            begin
                job_r <= pick;
                dir_r <= (pick == 4'(`JOB_RETURN));
                w_start_r <= (pick != 4'(`JOB_FLAG));
                w_first_r <= `TABLE_FIRST;
                w_last_r <= `TABLE_LAST;
                case (pick)
                    4'(`JOB_REGS):
                    begin
                        space_r <= SP_REG;
                        w_first_r <= `REG_FIRST;
                        w_last_r <= `REG_LAST;
                    end
                    4'(`JOB_INPUT): space_r <= SP_INPUT;
                    4'(`JOB_OUTPUT): space_r <= SP_OUTPUT;
                    4'(`JOB_OVERRIDE): space_r <= SP_OVERRIDE;
                    4'(`JOB_TRANS): space_r <= SP_TRANS;
                    4'(`JOB_SCRATCH):
                    begin
                        space_r <= SP_SCRATCH;
                        w_last_r <= `SCRATCH_LAST;
                    end
                    4'(`JOB_BANK):
                    begin
                        space_r <= SP_REG;
                        w_first_r <= start_ptr_r[12:0];
                        w_last_r <= end_ptr_r[12:0];
                    end
                    4'(`JOB_RETURN):
                    begin
                        space_r <= SP_REG;
                        w_first_r <= `RETURN_WORD_REG;
                        w_last_r <= `RETURN_WORD_REG;
                    end
                    default: space_r <= SP_BIT;
                endcase
            end
        end
    end

    // Memory port steering
    always_comb
    begin
        mst_rd_nxt = 1'b0;
        mst_wr_nxt = 1'b0;
        mst_space_nxt = SP_REG;
        mst_addr_nxt = 13'h0000;
        mst_wdata_nxt = 16'h0000;
        bak_rd_nxt = 1'b0;
        bak_wr_nxt = 1'b0;
        bak_space_nxt = space_r;
        bak_addr_nxt = 13'h0000;
        bak_wdata_nxt = 16'h0000;
        if (state_r == S_PTR && ptr_step_r <= 2'h1)
        begin
            mst_rd_nxt = 1'b1;
            mst_addr_nxt = (ptr_step_r == 2'h0) ? `BANK_START_REG : `BANK_END_REG;
        end
        else if (dir_r)
        begin
            bak_rd_nxt = w_rd;
            bak_addr_nxt = w_rd_addr;
            mst_wr_nxt = w_wr;
            mst_space_nxt = space_r;
            mst_addr_nxt = w_wr_addr;
            mst_wdata_nxt = w_wr_data;
        end
        else
        begin
            mst_rd_nxt = w_rd;
            mst_space_nxt = space_r;
            mst_addr_nxt = w_rd_addr;
            bak_wr_nxt = w_wr;
            bak_addr_nxt = w_wr_addr;
            bak_wdata_nxt = w_wr_data;
        end
        if (state_r == S_FLAG)
        begin
            bak_wr_nxt = 1'b1;
            bak_space_nxt = SP_BIT;
            bak_addr_nxt = flag_point;
            bak_wdata_nxt = `FLAG_ON;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mst_rd_o <= 1'b0;
            mst_wr_o <= 1'b0;
            mst_space_o <= SP_REG;
            mst_addr_o <= 13'h0000;
            mst_wdata_o <= 16'h0000;
            bak_rd_o <= 1'b0;
            bak_wr_o <= 1'b0;
            bak_space_o <= SP_REG;
            bak_addr_o <= 13'h0000;
            bak_wdata_o <= 16'h0000;
        end
        else
        begin
            mst_rd_o <= mst_rd_nxt;
            mst_wr_o <= mst_wr_nxt;
            mst_space_o <= mst_space_nxt;
            mst_addr_o <= mst_addr_nxt;
            mst_wdata_o <= mst_wdata_nxt;
            bak_rd_o <= bak_rd_nxt;
            bak_wr_o <= bak_wr_nxt;
            bak_space_o <= bak_space_nxt;
            bak_addr_o <= bak_addr_nxt;
            bak_wdata_o <= bak_wdata_nxt;
        end
    end

    // Backup role tracking, event wins
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_online_r <= 1'b0;
            prev_sel_r <= 1'b0;
            init_pending_r <= 1'b0;
        end
        else
        begin
            prev_online_r <= backup_online_i;
            prev_sel_r <= backup_cpu_sel_i;
            if (new_backup)
                init_pending_r <= 1'b1;
            else if (state_r == S_EVAL)
                init_pending_r <= 1'b0;
        end
    end

    // Sweep timer, idle cycles only
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sweep_cnt_r <= 22'h000000;
            sweep_last_r <= 22'h000000;
            sweep_count_r <= 16'h0000;
        end
        else if (sweep_start_i)
        begin
            sweep_last_r <= sweep_cnt_r;
            sweep_cnt_r <= 22'h000000;
        end
        else
        begin
            if (!busy_o && sweep_cnt_r != sweep_limit)
                sweep_cnt_r <= sweep_cnt_r + 22'h000001;
            if (state_r == S_DONE)
                sweep_count_r <= sweep_count_r + 16'h0001;
        end
    end

    // Overrun flag, set wins
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fault_r <= 1'b0;
            sweep_fault_o <= 1'b0;
        end
        else
        begin
            if (!busy_o && !sweep_start_i && sweep_cnt_r + 22'h000001 == sweep_limit)
                fault_r <= 1'b1;
            else if (reg_wr_i && reg_addr_i == `OFS_CONTROL &&
                     reg_wdata_i[`CTL_CLEAR_FAULT])
                fault_r <= 1'b0;
            sweep_fault_o <= fault_r;
        end
    end

    // Register port
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hold_r <= 1'b0;
        else if (reg_wr_i && reg_addr_i == `OFS_CONTROL)
            hold_r <= reg_wdata_i[`CTL_HOLD];
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (reg_addr_i)
            `OFS_STATUS:
            begin
                rdata_nxt[`ST_BUSY] = busy_o;
                rdata_nxt[`ST_INIT_PENDING] = init_pending_r;
                rdata_nxt[`ST_SWEEP_FAULT] = fault_r;
                rdata_nxt[`ST_BANK_SKIPPED] = bank_skipped_r;
                rdata_nxt[`ST_FLAG_ALT] = backup_flag_location_jumper_i;
                rdata_nxt[`ST_INIT_DONE] = init_done_r;
            end
            `OFS_CONTROL: rdata_nxt[`CTL_HOLD] = hold_r;
            `OFS_SWEEP_TIME: rdata_nxt[21:0] = sweep_last_r;
            `OFS_SWEEP_COUNT: rdata_nxt[15:0] = sweep_count_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0000_0000;
        else
            reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h0000_0000;
    end

endmodule : redundant_cpu_data_transfer_control

// [bench/xfer_ctl_props.sv]
/* Checker on the transfer control ports.
   Assumes it is bound to the top module. */
module xfer_ctl_props (
    input wire logic clock_i, rst_n_i, busy_o, mst_rd_o, mst_wr_o, bak_wr_o,
    input wire logic table_copy_select_i, table_copy_request_output_i,
    input wire logic backup_to_master_select_i, backup_to_master_request_output_i,
    input wire logic bank_copy_select_i, bank_copy_request_output_i,
    input wire logic backup_init_jumper_i, backup_flag_location_jumper_i,
    input wire logic [2:0] mst_space_o, bak_space_o,
    input wire logic [12:0] mst_addr_o, bak_addr_o,
    input wire logic [15:0] bak_wdata_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic ij = backup_init_jumper_i;
    wire logic bw = bak_wr_o;
    property p_flag;
        bw && bak_space_o == 3'h6 |-> bak_wdata_o == 16'h0001
            && bak_addr_o == (backup_flag_location_jumper_i ? 13'h03FE : 13'h0400);
    endproperty
    a_flag: assert property (p_flag) else $error("flag point wrong");
    property p_ret;
        mst_wr_o |-> mst_space_o == 3'h0 && mst_addr_o == 13'h00FE
            && (backup_to_master_select_i || backup_to_master_request_output_i);
    endproperty
    a_ret: assert property (p_ret) else $error("master write wrong");
    property p_tbl;
        bw && bak_space_o inside {3'h2, 3'h4}
            |-> ij || table_copy_select_i || table_copy_request_output_i;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table copy not enabled");
    property p_ini;
        bw && bak_space_o inside {3'h1, 3'h3, 3'h5} |-> ij;
    endproperty
    a_ini: assert property (p_ini) else $error("init copy without jumper");
    property p_bank;
        bw && bak_space_o == 3'h0 |-> ij || bank_copy_select_i || bank_copy_request_output_i;
    endproperty
    a_bank: assert property (p_bank) else $error("bank copy not enabled");
    property p_wbusy;
        bw || mst_wr_o |-> busy_o;
    endproperty
    a_wbusy: assert property (p_wbusy) else $error("write outside sweep");
    property p_ptr0;
        $rose(busy_o) |-> ##[1:2] (mst_rd_o && mst_addr_o == 13'h00FF);
    endproperty
    a_ptr0: assert property (p_ptr0) else $error("start pointer not read");
    property p_ptr1;
        $rose(busy_o) |-> ##[2:3] (mst_rd_o && mst_addr_o == 13'h0100);
    endproperty
    a_ptr1: assert property (p_ptr1) else $error("end pointer not read");
    c_ini: cover property (bw && bak_space_o == 3'h1);
    c_ret: cover property (mst_wr_o);
    c_alt: cover property (bw && bak_space_o == 3'h6 && backup_flag_location_jumper_i);
endmodule : xfer_ctl_props

bind redundant_cpu_data_transfer_control xfer_ctl_props u_xfer_ctl_props (.*);

// [bench/cpu_pair.sv]
/* Memory model of master and backup CPU, counting writes per sweep.
   Assumes reads are answered in the following cycle. */
module cpu_pair (
    input wire logic clock_i, sweep_start_i, mst_rd_o, mst_wr_o, bak_rd_o, bak_wr_o,
    input wire logic [2:0] mst_space_o, bak_space_o,
    input wire logic [12:0] mst_addr_o, bak_addr_o,
    input wire logic [15:0] mst_wdata_o, bak_wdata_o, start_ptr, end_ptr, ret_word,
    output logic [15:0] mst_rdata_i, bak_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    int c[8], bad, lo = -1;
    logic [15:0] mw;
    function automatic logic [15:0] md(input logic [2:0] s, input logic [12:0] a);
        if (s == 3'h0 && a == 13'h00FF)
            return start_ptr;
        if (s == 3'h0 && a == 13'h0100)
            return end_ptr;
        return {s, a} ^ 16'hA5C3;
    endfunction : md
    always @(posedge clock_i)
    begin
        mst_rdata_i <= mst_rd_o ? md(mst_space_o, mst_addr_o) : ~mst_rdata_i;
        bak_rdata_i <= bak_rd_o ? ret_word : ~bak_rdata_i;
        if (sweep_start_i)
        begin
            c = '{default: 0};
            bad = 0;
            lo = -1;
        end
        if (bak_wr_o)
        begin
            c[bak_space_o]++;
            if (bak_space_o == 3'h0 && lo < 0)
                lo = bak_addr_o;
            if (bak_space_o != 3'h6 && bak_wdata_o !== md(bak_space_o, bak_addr_o))
                bad++;
        end
        if (mst_wr_o)
        begin
            c[7]++;
            mw = mst_wdata_o;
        end
    end
endmodule : cpu_pair

// [bench/tb_redundant_cpu_data_transfer_control.sv]
/* Random and corner sweeps, init and timer checks.
   Assumes limits of 40 and 60 cycles. */
`include "xfer_ctl_params.svh"
module tb_redundant_cpu_data_transfer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 0, rst_n_i = 0, sweep_start_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic table_copy_select_i = 0, backup_to_master_select_i = 0, bank_copy_select_i = 0;
    logic backup_init_jumper_i = 0, backup_flag_location_jumper_i = 0, sweep_limit_jumper_i = 0;
    logic table_copy_request_output_i = 0, backup_to_master_request_output_i = 0;
    logic bank_copy_request_output_i = 0, backup_cpu_sel_i = 0, backup_online_i = 0;
    logic mst_rd_o, mst_wr_o, bak_rd_o, bak_wr_o, busy_o, sweep_done_o, sweep_fault_o;
    logic [2:0] mst_space_o, bak_space_o;
    logic [12:0] mst_addr_o, bak_addr_o;
    logic [15:0] mst_wdata_o, bak_wdata_o, mst_rdata_i, bak_rdata_i;
    logic [15:0] start_ptr = 1, end_ptr = 1, ret_word = 0;
    logic [3:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, r;
    logic [31:0] cor[6] = '{32'h00000003, 32'h00021001, 32'h00060002, 32'h10001000,
        32'h00010001, 32'h00040008};
    int fails = 0, check_count = 0, seed = 32'h6e570860, nsw = 0, i, k;
    always #50 clock_i = ~clock_i;
    redundant_cpu_data_transfer_control #(.SWEEP_SHORT_CYC(40), .SWEEP_LONG_CYC(60))
        u_redundant_cpu_data_transfer_control (.*);
    cpu_pair u_cpu_pair (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic rwr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : rwr
    task automatic rrd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask : rrd
    task automatic sweep(input int ini);
        logic t, v;
        @(posedge clock_i);
        sweep_start_i <= 1'b1;
        @(posedge clock_i);
        sweep_start_i <= 1'b0;
        nsw++;
        for (i = 0; i < 9000 && sweep_done_o !== 1'b1; i++)
            @(negedge clock_i);
        if (i == 9000)
        begin
            fails++;
            give_verdict();
        end
        t = table_copy_select_i | table_copy_request_output_i | ini[0];
        v = (bank_copy_select_i | bank_copy_request_output_i) && start_ptr >= 16'h0001
            && end_ptr <= 16'h1000 && start_ptr <= end_ptr;
        chk(u_cpu_pair.c[0], (v ? end_ptr - start_ptr + 1 : 0) + ini * `REG_LAST);
        chk(u_cpu_pair.lo, ini ? 1 : v ? start_ptr : -1);
        chk(u_cpu_pair.c[2] + u_cpu_pair.c[4], t * 2 * `TABLE_LAST);
        chk(u_cpu_pair.c[1] + u_cpu_pair.c[3], ini * 2 * `TABLE_LAST);
        chk(u_cpu_pair.c[5] + u_cpu_pair.c[6], ini * `SCRATCH_LAST + 1);
        chk(u_cpu_pair.c[7], backup_to_master_select_i | backup_to_master_request_output_i);
        if (u_cpu_pair.c[7] == 1)
            chk(u_cpu_pair.mw, ret_word);
        chk(u_cpu_pair.bad, 0);
        $display("sweep %0d done", nsw);
        @(posedge clock_i);
    endtask : sweep
    initial
    begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rrd(4'h4, 32'h0);
        rwr(4'h2, 32'hFFFFFFFF);
        rrd(4'h2, 32'h0);
        backup_init_jumper_i <= 1'b1;
        backup_online_i <= 1'b1;
        sweep(1);
        sweep(0);
        backup_cpu_sel_i <= 1'b1;
        sweep(1);
        backup_init_jumper_i <= 1'b0;
        backup_cpu_sel_i <= 1'b0;
        sweep(0);
        for (k = 0; k < 24; k++)
        begin
            r = $random(seed);
            {table_copy_select_i, backup_to_master_select_i, bank_copy_select_i,
                table_copy_request_output_i, backup_to_master_request_output_i,
                bank_copy_request_output_i, backup_flag_location_jumper_i}
                <= {r[6:5], r[4] | (k < 6), r[3:0]};
            {start_ptr, end_ptr} <= (k < 6) ? cor[k] : {13'h0, r[10:8] + 3'h1, 13'h0, r[14:12] + 3'h1};
            ret_word <= r[31:16];
            sweep(0);
        end
        rrd(4'hC, nsw);
        for (k = 0; k < 2; k++)
        begin
            sweep_limit_jumper_i <= ~k[0];
            sweep(0);
            rwr(4'h4, 32'h1);
            repeat (25) @(posedge clock_i);
            #1;
            chk(sweep_fault_o, 1'b0);
            repeat (25) @(posedge clock_i);
            #1;
            chk(sweep_fault_o, sweep_limit_jumper_i);
            repeat (20) @(posedge clock_i);
            #1;
            chk(sweep_fault_o, 1'b1);
            $display("limit %0d done", k);
        end
        give_verdict();
    end
endmodule : tb_redundant_cpu_data_transfer_control
